// ==== led_function_select.v ====
// Indicator function select, polarity and blink logic with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Behaviour
// [RULE_01] Third code 0010: duplex on, collision blinks
// [RULE_02] Third 0110 10/1000 link, 0111 10 only
// [RULE_03] Third 0000 link, 0101 transmit
// [RULE_04] Second select bits 7:4; 0000 receive
// [RULE_05] Second 0010: link on, receive blinks
// [RULE_06] Second 0101 100/fiber, 0110 100/1000, 0111 100
// [RULE_07] Second select ignored when first is 11
// [RULE_08] 0001 link/blink, 0011 activity, 0100 blink activity
// [RULE_09] 1000 off, 1001 on, 1010 hi-z, 1011 blink
// [RULE_10] Software avoids reserved codes 11xx
// [RULE_11] Polarity picks on level, off level or tristate
// [RULE_12] Blink period 42 to 670 ms
// [RULE_13] Activity pulse stretch 000 off up to 2.7 s; code reaches 64 ticks, about 1.3 s, at most
// [RULE_14] State passes polarity stage; hi-z drops enable
`include "indicator_map.vh"
module led_function_select #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire clock,
  input wire srst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire link_up,
  input wire full_duplex,
  input wire collision,
  input wire transmit,
  input wire receive,
  input wire fiber_link,
  input wire [1:0] link_speed,
  output reg second_indicator_pin,
  output reg second_indicator_oe,
  output reg third_indicator_pin,
  output reg third_indicator_oe
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [7:0] sync1, sync2, sync3;
  reg [7:0] status;
  wire [7:0] raw_in = {link_speed, fiber_link, receive, transmit, collision, full_duplex, link_up};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      always @(posedge clock) begin
        if (srst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          status[gi] <= 1'b0;
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            status[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate
  wire s_link = status[0];
  wire s_fdx = status[1];
  wire s_col = status[2];
  wire s_tx = status[3];
  wire s_rx = status[4];
  wire s_fiber = status[5];
  wire [1:0] s_speed = status[7:6];
  // ----------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------
  reg [15:0] func_sel, polarity, timer_ctl;
  reg aw_held, w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
  wire have_w = w_held || (s_axi_wvalid && s_axi_wready);
  wire do_write = have_aw && have_w;
  function [15:0] merge;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction
  always @(posedge clock) begin
    if (srst) begin
      func_sel <= `RST_FUNC_SEL;
      polarity <= `RST_POLARITY;
      timer_ctl <= `RST_TIMER;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case ({wa[7:2], 2'b00})
          `OFS_FUNC_SEL: func_sel <= merge(func_sel, wd, ws);
          `OFS_POLARITY: polarity <= merge(polarity, wd, ws);
          `OFS_TIMER: timer_ctl <= merge(timer_ctl, wd, ws);
          `OFS_STATUS: s_axi_bresp <= 2'h2;
          default: s_axi_bresp <= 2'h2;
        endcase
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end
  always @(posedge clock) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case ({s_axi_araddr[7:2], 2'b00})
        `OFS_FUNC_SEL: s_axi_rdata <= {16'h0000, func_sel};
        `OFS_POLARITY: s_axi_rdata <= {16'h0000, polarity};
        `OFS_TIMER: s_axi_rdata <= {16'h0000, timer_ctl};
        `OFS_STATUS: s_axi_rdata <= {20'h00000, third_indicator_oe, third_indicator_pin,
          second_indicator_oe, second_indicator_pin, status};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Time base, blink and stretch
  // ----------------------------------------
  reg [19:0] tick_cnt;
  reg tick;
  reg [7:0] phase;
  always @(posedge clock) begin
    if (srst) begin
      tick_cnt <= 20'h00000;
      tick <= 1'b0;
      phase <= 8'h00;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 1);
      if (tick_cnt == TICK_CYCLES - 1) begin
        tick_cnt <= 20'h00000;
        phase <= phase + 8'h01;
      end else begin
        tick_cnt <= tick_cnt + 20'h00001;
      end
    end
  end
  // Blink half period of 1,2,4,8,16 ticks gives 42..670 ms periods
  wire [2:0] blink_sel = timer_ctl[`BLINK_LSB+2:`BLINK_LSB];
  wire [2:0] blink_idx = (blink_sel > 3'h4) ? 3'h4 : blink_sel;
  wire blink = phase[blink_idx]; // [RULE_12]
  // Stretch length 1..64 ticks, from 21 ms up to 1.3 s windows
  wire [2:0] stretch_sel = timer_ctl[`STRETCH_LSB+2:`STRETCH_LSB];
  wire [7:0] stretch_len = 8'h01 << (stretch_sel - 3'h1);
  reg [7:0] act_cnt, rx_cnt, col_cnt;
  wire s_act = s_tx || s_rx;
  always @(posedge clock) begin
    if (srst) begin
      act_cnt <= 8'h00;
      rx_cnt <= 8'h00;
      col_cnt <= 8'h00;
    end else begin
      act_cnt <= s_act ? stretch_len : ((tick && act_cnt != 8'h00) ? act_cnt - 8'h01 : act_cnt);
      rx_cnt <= s_rx ? stretch_len : ((tick && rx_cnt != 8'h00) ? rx_cnt - 8'h01 : rx_cnt);
      col_cnt <= s_col ? stretch_len : ((tick && col_cnt != 8'h00) ? col_cnt - 8'h01 : col_cnt);
    end
  end
  wire no_stretch = (stretch_sel == 3'h0); // [RULE_13]
  wire act = no_stretch ? s_act : (s_act || act_cnt != 8'h00);
  wire rxa = no_stretch ? s_rx : (s_rx || rx_cnt != 8'h00);
  wire cola = no_stretch ? s_col : (s_col || col_cnt != 8'h00);
  // ----------------------------------------
  // Function decode: {hiz, lit}
  // ----------------------------------------
  wire [3:0] sel2 = func_sel[`SECOND_SEL_LSB+3:`SECOND_SEL_LSB];
  wire [3:0] sel3 = func_sel[`THIRD_SEL_LSB+3:`THIRD_SEL_LSB];
  wire [1:0] first_sel = func_sel[`FIRST_SEL_LSB+3:`FIRST_SEL_LSB+2];
  reg lit2, hiz2, lit3, hiz3;
  always @* begin
    hiz2 = 1'b0;
    case (sel2)
      4'h0: lit2 = s_rx; // [RULE_04]
      4'h1: lit2 = s_link && !(act && blink); // [RULE_08]
      4'h2: lit2 = s_link && !(rxa && blink); // [RULE_05]
      4'h3: lit2 = act; // [RULE_08]
      4'h4: lit2 = act && blink; // [RULE_08]
      4'h5: lit2 = s_link && (s_speed == 2'h1 || s_fiber); // [RULE_06]
      4'h6: lit2 = s_link && (s_speed == 2'h1 || s_speed == 2'h2); // [RULE_06]
      4'h7: lit2 = s_link && s_speed == 2'h1; // [RULE_06]
      4'h9: lit2 = 1'b1; // [RULE_09]
      4'ha: begin
        lit2 = 1'b0;
        hiz2 = 1'b1; // [RULE_09]
      end
      4'hb: lit2 = blink; // [RULE_09]
      default: lit2 = 1'b0;
    endcase
    if (first_sel == 2'h3) begin
      lit2 = 1'b0; // [RULE_07]
      hiz2 = 1'b0;
    end
  end
  always @* begin
    hiz3 = 1'b0;
    case (sel3)
      4'h0: lit3 = s_link; // [RULE_03]
      4'h1: lit3 = s_link && !(act && blink); // [RULE_08]
      4'h2: lit3 = s_fdx ? 1'b1 : (cola && blink); // [RULE_01]
      4'h3: lit3 = act; // [RULE_08]
      4'h4: lit3 = act && blink; // [RULE_08]
      4'h5: lit3 = s_tx; // [RULE_03]
      4'h6: lit3 = s_link && (s_speed == 2'h0 || s_speed == 2'h2); // [RULE_02]
      4'h7: lit3 = s_link && s_speed == 2'h0; // [RULE_02]
      4'h9: lit3 = 1'b1; // [RULE_09]
      4'ha: begin
        lit3 = 1'b0;
        hiz3 = 1'b1; // [RULE_09]
      end
      4'hb: lit3 = blink; // [RULE_09]
      default: lit3 = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Polarity stage and pins
  // ----------------------------------------
  wire [1:0] second_indicator_polarity = polarity[`SECOND_POL_LSB+1:`SECOND_POL_LSB];
  wire [1:0] pol3 = polarity[`THIRD_POL_LSB+1:`THIRD_POL_LSB];
  always @(posedge clock) begin
    if (srst) begin
      second_indicator_pin <= 1'b0;
      second_indicator_oe <= 1'b0;
      third_indicator_pin <= 1'b0;
      third_indicator_oe <= 1'b0;
    end else begin
      second_indicator_pin <= second_indicator_polarity[0] ~^ lit2; // [RULE_11]
      second_indicator_oe <= !hiz2 && (lit2 || !second_indicator_polarity[1]); // [RULE_14]
      third_indicator_pin <= pol3[0] ~^ lit3; // [RULE_11]
      third_indicator_oe <= !hiz3 && (lit3 || !pol3[1]); // [RULE_14]
    end
  end
endmodule

// ==== indicator_map.vh ====
// Register offsets, field positions, reset values and timing counts of the indicator block
`ifndef INDICATOR_MAP_VH
`define INDICATOR_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_FUNC_SEL 8'h10
`define OFS_POLARITY 8'h14
`define OFS_TIMER 8'h18
`define OFS_STATUS 8'h1c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIRST_SEL_LSB 0
`define SECOND_SEL_LSB 4
`define THIRD_SEL_LSB 8
`define SECOND_POL_LSB 2
`define THIRD_POL_LSB 4
`define STRETCH_LSB 12
`define BLINK_LSB 8
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FUNC_SEL 16'h101e
`define RST_POLARITY 16'h4400
`define RST_TIMER 16'h4100
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_HZ 25000000
`define TICK_MS 21
`define TICK_CYCLES ((`CLOCK_HZ / 1000) * `TICK_MS)
`endif

// ==== indicator_lamp.sv ====
// Lamp model hanging on one indicator pin
`timescale 1ns/1ns
module indicator_lamp (
  input wire pin,
  input wire oe,
  output wire lit
);
  // Lamp to ground: lit only while the pin is driven high
  assign lit = oe && pin;
endmodule

// ==== led_function_select_checker.sv ====
// Port assertions of the indicator block
`timescale 1ns/1ns
`include "indicator_map.vh"
module led_function_select_checker (
  input wire clock,
  input wire srst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire second_indicator_oe,
  input wire third_indicator_oe
);
  // ----------------------------------------
  // Shadow of the function select register
  // ----------------------------------------
  reg [15:0] sel;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  always @(posedge clock) begin
    if (srst) begin
      sel <= `RST_FUNC_SEL;
    end else if (wr_go && s_axi_awaddr == `OFS_FUNC_SEL) begin
      sel <= s_axi_wdata[15:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  rd_answer_a: assert property (rd_go |=> s_axi_rvalid)
    else $error("read answer missing");
  wr_answer_a: assert property (wr_go |=> s_axi_bvalid)
    else $error("write answer missing");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  reset_quiet_a: assert property ($fell(srst) |-> !second_indicator_oe && !third_indicator_oe
    && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  status_ro_a: assert property (wr_go && s_axi_awaddr == `OFS_STATUS |=> s_axi_bresp == 2'h2)
    else $error("status write not refused");
  unmapped_rd_a: assert property (rd_go && s_axi_araddr[7:4] != 4'h1 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  third_hiz_a: assert property ((sel[11:8] == 4'ha) [*3] |-> !third_indicator_oe)
    else $error("third pin driven in high impedance");
  second_hiz_a: assert property ((sel[7:4] == 4'ha && sel[3:2] != 2'h3) [*3] |->
    !second_indicator_oe)
    else $error("second pin driven in high impedance");
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
  cover property ($fell(third_indicator_oe));
endmodule
bind led_function_select led_function_select_checker i_chk (.*);

// ==== testbench.sv ====
// Self-checking bench of the indicator block
`timescale 1ns/1ns
`define CHECK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  reg clock = 0, srst = 1, probe = 0, last3 = 0;
  reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg [31:0] s_axi_wdata = 0, seed = 86247;
  wire [3:0] s_axi_wstrb = 4'hf;
  reg link_up = 0, full_duplex = 0, collision = 0, transmit = 0, receive = 0, fiber_link = 0;
  reg [1:0] link_speed = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lit2, lit3;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire second_indicator_pin, second_indicator_oe, third_indicator_pin, third_indicator_oe;
  wire [5:0] pins = {second_indicator_oe, second_indicator_pin & second_indicator_oe,
    third_indicator_oe, third_indicator_pin & third_indicator_oe, lit2, lit3};
  wire [1:0] blink_seen = {third_indicator_oe, third_indicator_pin ^ last3};
  reg [33:0] q[$];
  reg [33:0] e;
  reg [35:0] tc [0:13];
  reg [3:0] want;
  integer err_total = 0, tests_run = 0, cycles = 0, i;
  always #20 clock = ~clock;
  led_function_select #(.TICK_CYCLES(4)) i_dut (.*);
  indicator_lamp i_lamp2 (.pin(second_indicator_pin), .oe(second_indicator_oe), .lit(lit2));
  indicator_lamp i_lamp3 (.pin(third_indicator_pin), .oe(third_indicator_oe), .lit(lit3));
  // ----------------------------------------
  // Stimulus helpers
  // ----------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    reg aok, wok, bok;
    begin
      @(posedge clock);
      q.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      bok = 0;
      while (!bok) begin
        @(negedge clock);
        aok = s_axi_awvalid && s_axi_awready;
        wok = s_axi_wvalid && s_axi_wready;
        bok = s_axi_bvalid;
        @(posedge clock);
        if (aok) s_axi_awvalid <= 1'h0;
        if (wok) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input [7:0] a, input [33:0] x);
    reg aok, rok;
    begin
      @(posedge clock);
      q.push_back(x);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      rok = 0;
      while (!rok) begin
        @(negedge clock);
        aok = s_axi_arvalid && s_axi_arready;
        rok = s_axi_rvalid;
        @(posedge clock);
        if (aok) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
    end
  endtask
  task pr(input [1:0] m, input [3:0] x);
    begin
      @(posedge clock);
      q.push_back({m, 26'h0, x, x[2], x[0]});
      probe <= 1'h1;
      @(posedge clock);
      probe <= 1'h0;
    end
  endtask
  task end_of_test;
    begin
      $display("errors %0d in %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // Result monitor and timeout
  // ----------------------------------------
  always @(negedge clock) begin
    if (s_axi_bvalid && s_axi_bready) begin
      e = q.pop_front();
      `CHECK("bresp", e[33:32], s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      e = q.pop_front();
      `CHECK("rdata", e, {s_axi_rresp, s_axi_rdata})
    end
    if (probe) begin
      e = q.pop_front();
      if (e[33:32] == 2'h0) `CHECK("pins", e[5:0], pins)
      if (e[33:32] == 2'h1) `CHECK("blink", 2'h3, blink_seen)
      last3 = third_indicator_pin;
    end
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tc[0] = {16'h0000, 8'h14, 8'h88, 4'hf};
    tc[1] = {16'h0570, 8'h14, 8'h81, 4'he};
    tc[2] = {16'h0660, 8'h14, 8'h82, 4'hf};
    tc[3] = {16'h0750, 8'h14, 8'h86, 4'he};
    tc[4] = {16'h0220, 8'h14, 8'hc0, 4'hf};
    tc[5] = {16'h0330, 8'h14, 8'h80, 4'ha};
    tc[6] = {16'h0330, 8'h14, 8'h90, 4'hf};
    tc[7] = {16'h0440, 8'h14, 8'h80, 4'ha};
    tc[8] = {16'h0110, 8'h14, 8'h80, 4'hf};
    tc[9] = {16'h09ac, 8'h14, 8'h80, 4'hb};
    tc[10] = {16'h0a80, 8'h14, 8'h80, 4'h8};
    tc[11] = {16'h0980, 8'h28, 8'h80, 4'h2};
    tc[12] = {16'h09a0, 8'h14, 8'h80, 4'h3};
    tc[13] = {16'h0220, 8'h14, 8'h80, 4'he};
    repeat (4) @(posedge clock);
    srst <= 1'h0;
    rd(8'h10, 34'h101e);
    rd(8'h14, 34'h4400);
    rd(8'h18, 34'h4100);
    rd(8'h20, {2'h2, 32'h0});
    pr(2'h0, 4'hf);
    wr(8'h1c, 32'h0, 2'h2);
    wr(8'h18, 32'h0, 2'h0);
    for (i = 0; i < 14; i++) begin
      wr(8'h14, {24'h0, tc[i][19:12]}, 2'h0);
      wr(8'h10, {16'h0, tc[i][35:20]}, 2'h0);
      @(posedge clock);
      {link_up, full_duplex, collision, transmit, receive, fiber_link, link_speed} <= tc[i][11:4];
      repeat (8) @(posedge clock);
      pr(2'h0, tc[i][3:0]);
    end
    rd(8'h10, 34'h0220);
    rd(8'h1c, {2'h0, 32'h00000b01});
    wr(8'h10, 32'h0760, 2'h0);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      @(posedge clock);
      link_up <= seed[0];
      link_speed <= seed[2:1] % 2'h3;
      repeat (8) @(posedge clock);
      want = {1'h1, seed[0] && link_speed != 2'h0, 1'h1, seed[0] && link_speed == 2'h0};
      pr(2'h0, want);
    end
    wr(8'h18, 32'h3000, 2'h0);
    wr(8'h10, 32'h0330, 2'h0);
    @(posedge clock);
    transmit <= 1'h1;
    repeat (8) @(posedge clock);
    transmit <= 1'h0;
    repeat (8) @(posedge clock);
    pr(2'h0, 4'hf);
    repeat (24) @(posedge clock);
    pr(2'h0, 4'ha);
    wr(8'h10, 32'h0b00, 2'h0);
    pr(2'h2, 4'h0);
    repeat (2) @(posedge clock);
    pr(2'h1, 4'h0);
    repeat (2) @(posedge clock);
    pr(2'h1, 4'h0);
    end_of_test;
  end
endmodule
